// ---- rtl/acc_ctrl.sv ----
// Amplifier channel command controller: Wishbone register slave that runs
// calibration, auto-calibration, input source, peak store and adaptation
// commands on the selected channels and serialises ASCII replies.
// Assumes synchronous inputs and measured values fresh every clock.
//
// Function
// - One-shot calibrate starts cal, unlocks, keeps auto.
// - Calibration running flag marks unstable values.
// - Cal status query replies 0 idle, 1 running.
// - Auto-cal 0 off, 1 on; reset enabled.
// - Auto-cal starts on plug-in or long overflow.
// - Auto-cal only for bridge-like transducer types.
// - Auto-cal query replies enable per subchannel.
// - Input source accepts 40, 41, 42.
// - Input source 43 and 46 rejected.
// - Input source query replies selected code.
// - Clear selects max, min or peak-peak store.
// - Clear loads min/max with value, peak-peak zero.
// - Peak-peak uses its own private min/max trackers.
// - Stores exist only when created in configuration.
// - Virtual channel has no peak stores.
// - Freeze 1 suspends, 0 resumes store updating.
// - All stores update-enabled after reset.
// - Freeze query replies store number and hold bit.
// - Missing store gives empty field between colons.
// - Store list query replies available store numbers.
// - Adaptation sets excitation, type, optional sensitivity.
// - Excitation 10 and 13 accepted, others rejected.
// - Commands act only on selected channel/subchannels.
`timescale 1ns/10ps

module acc_ctrl #(
  parameter int CAL_CYC = acc_pkg::CAL_CYCLES,
  parameter int OVF_CYC = acc_pkg::OVF_CYCLES
) (
  input  wire logic                                      clk_in,
  input  wire logic                                      rstn_in,
  input  wire logic                                      wb_cyc_in,
  input  wire logic                                      wb_stb_in,
  input  wire logic                                      wb_we_in,
  input  wire logic [7:0]                                wb_adr_in,
  input  wire logic [3:0]                                wb_sel_in,
  input  wire logic [31:0]                               wb_dat_in,
  output logic      [31:0]                               wb_dat_out,
  output logic                                           wb_ack_out,
  input  wire logic [acc_pkg::NSLOT-1:0][15:0]           meas_in,
  input  wire logic [acc_pkg::NSLOT-1:0]                 sensor_plug_in,
  input  wire logic [acc_pkg::NSLOT-1:0]                 overflow_in,
  output acc_pkg::acc_cfg_s  [acc_pkg::NSLOT-1:0]        cfg_out,
  output acc_pkg::acc_peak_s [acc_pkg::NSLOT-1:0]        peak_out,
  output logic      [2:0]                                store_created_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    acc_pkg::acc_cfg_s  cfg;
    acc_pkg::acc_peak_s pk;
    logic [15:0]        ppmx;
    logic [15:0]        ppmn;
    logic [29:0]        cal_cnt;
    logic [29:0]        ovf_cnt;
  } acc_slot_s;

  typedef struct packed {
    acc_slot_s [acc_pkg::NSLOT-1:0] slot;
    logic [acc_pkg::NCH-1:0]        chsel;
    logic [acc_pkg::NSUB-1:0]       subsel;
    logic [2:0]                     created;
    logic [16:0]                    p1;
    logic [16:0]                    p2;
    logic [16:0]                    p3;
    logic                           err;
    logic                           ack;
    logic [31:0]                    dat;
    acc_pkg::acc_rstate_e           rst;
    logic [3:0]                     rop;
    logic [1:0]                     rstore;
    logic [3:0]                     rslot;
    logic [2:0]                     ridx;
  } acc_state_s;

  acc_state_s s_r;
  acc_state_s s_nxt;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] wmerge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : wmerge

  function automatic logic is_sel(input acc_state_s st, input int i);
    return st.chsel[i / acc_pkg::NSUB] & st.subsel[i % acc_pkg::NSUB];
  endfunction : is_sel

  // First selected slot after position frm; bit 4 flags that one exists
  function automatic logic [4:0] next_sel(input acc_state_s st, input int frm);
    logic [4:0] r;
    r = 5'h00;
    for (int i = acc_pkg::NSLOT - 1; i >= 0; i--) begin
      if (i > frm && is_sel(st, i)) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : next_sel

  function automatic logic is_bridge(input logic [9:0] tt);
    return (tt >= acc_pkg::TT_BR_LO) && (tt <= acc_pkg::TT_BR_HI);
  endfunction : is_bridge

  // One character of a slot's reply field; zero marks the field's end
  function automatic logic [7:0] fchar(input logic [3:0] op, input acc_slot_s sl,
                                       input logic virt, input logic [2:0] created,
                                       input logic [1:0] store, input logic [2:0] idx);
    logic [4:0][7:0] s;
    int              n;
    s = '0;
    n = 0;
    if (op == acc_pkg::OP_CAL_Q) begin
      s[0] = acc_pkg::CH_ZERO + 8'(sl.cfg.cal_run);
    end else if (op == acc_pkg::OP_ACL_Q) begin
      s[0] = acc_pkg::CH_ZERO + 8'(sl.cfg.auto_adjust_enable_cmd);
    end else if (op == acc_pkg::OP_AIS_Q) begin
      s[0] = acc_pkg::CH_ZERO + 8'(sl.cfg.src / 6'h0A);
      s[1] = acc_pkg::CH_ZERO + 8'(sl.cfg.src % 6'h0A);
    end else if (op == acc_pkg::OP_HPV_Q) begin
      if (!virt && created[store - 2'h1]) begin
        s[0] = acc_pkg::CH_ZERO + 8'(store);
        s[1] = acc_pkg::CH_COMMA;
        s[2] = acc_pkg::CH_ZERO + 8'(sl.pk.frz[store - 2'h1]);
      end
    end else if (op == acc_pkg::OP_HPV_LIST && !virt) begin
      for (int k = 0; k < 3; k++) begin
        if (created[k]) begin
          if (n != 0) begin
            s[n] = acc_pkg::CH_COMMA;
            n++;
          end
          s[n] = acc_pkg::CH_ZERO + 8'(k + 1);
          n++;
        end
      end
    end
    return (idx < 3'h5) ? s[idx] : 8'h00;
  endfunction : fchar

  // ----------------------------------------------------------------------
  // Reply character at the head of the walker
  // ----------------------------------------------------------------------
  logic [7:0] cur_char;
  logic [4:0] nxt_slot;
  logic       field_end;

  always_comb begin
    cur_char  = 8'h00;
    field_end = 1'b0;
    nxt_slot  = next_sel(s_r, int'(s_r.rslot));
    case (s_r.rst)
      acc_pkg::R_FIELD: begin
        cur_char = fchar(s_r.rop, s_r.slot[s_r.rslot], (s_r.rslot / 4'(acc_pkg::NSUB)) ==
                         4'(acc_pkg::VIRT_CH), s_r.created, s_r.rstore, s_r.ridx);
        if (cur_char == 8'h00) begin
          field_end = 1'b1;
          if (!nxt_slot[4]) begin
            cur_char = acc_pkg::CH_TERM;
          end else if (s_r.rop == acc_pkg::OP_HPV_Q || s_r.rop == acc_pkg::OP_HPV_LIST ||
                       (nxt_slot[3:0] / 4'(acc_pkg::NSUB)) != (s_r.rslot / 4'(acc_pkg::NSUB))) begin
            cur_char = acc_pkg::CH_COLON;
          end else begin
            cur_char = acc_pkg::CH_COMMA;
          end
        end
      end
      acc_pkg::R_TERM: cur_char = acc_pkg::CH_TERM;
      default:         cur_char = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  logic        req;
  logic        cmd_go;
  logic [3:0]  op;
  logic [15:0] v1;
  logic [15:0] v2;
  logic        p1_on;
  logic        bad;
  logic        virt;
  logic        sel_i;
  logic        trig;
  logic [1:0]  store;
  logic [4:0]  first;
  logic signed [15:0] m;

  always_comb begin
    s_nxt  = s_r;
    s_nxt.ack = 1'b0;
    req    = wb_cyc_in & wb_stb_in & ~s_r.ack;
    cmd_go = req & wb_we_in & (wb_adr_in == acc_pkg::ADR_CMD);
    op     = wb_dat_in[3:0];
    v1     = s_r.p1[15:0];
    v2     = s_r.p2[15:0];
    p1_on  = s_r.p1[acc_pkg::PARAM_PRESENT];
    store  = p1_on ? v1[1:0] : 2'h1;
    bad    = 1'b0;
    first  = next_sel(s_r, -1);
    virt   = 1'b0;
    sel_i  = 1'b0;
    trig   = 1'b0;
    m      = '0;

    // Bus slave: one wait state, unmapped reads return zero
    if (req) begin
      s_nxt.ack = 1'b1;
      s_nxt.dat = 32'h0000_0000;
      if (wb_we_in) begin
        if (wb_adr_in == acc_pkg::ADR_CHSEL) begin
          s_nxt.chsel = 5'(wmerge(32'(s_r.chsel), wb_dat_in, wb_sel_in));
        end else if (wb_adr_in == acc_pkg::ADR_SUBSEL) begin
          s_nxt.subsel = 2'(wmerge(32'(s_r.subsel), wb_dat_in, wb_sel_in));
        end else if (wb_adr_in == acc_pkg::ADR_PARAM1) begin
          s_nxt.p1 = 17'(wmerge(32'(s_r.p1), wb_dat_in, wb_sel_in));
        end else if (wb_adr_in == acc_pkg::ADR_PARAM2) begin
          s_nxt.p2 = 17'(wmerge(32'(s_r.p2), wb_dat_in, wb_sel_in));
        end else if (wb_adr_in == acc_pkg::ADR_PARAM3) begin
          s_nxt.p3 = 17'(wmerge(32'(s_r.p3), wb_dat_in, wb_sel_in));
        end else if (wb_adr_in == acc_pkg::ADR_STORE_CFG) begin
          s_nxt.created = 3'(wmerge(32'(s_r.created), wb_dat_in, wb_sel_in));
        end
      end else begin
        if (wb_adr_in == acc_pkg::ADR_CHSEL) begin
          s_nxt.dat = 32'(s_r.chsel);
        end else if (wb_adr_in == acc_pkg::ADR_SUBSEL) begin
          s_nxt.dat = 32'(s_r.subsel);
        end else if (wb_adr_in == acc_pkg::ADR_PARAM1) begin
          s_nxt.dat = 32'(s_r.p1);
        end else if (wb_adr_in == acc_pkg::ADR_PARAM2) begin
          s_nxt.dat = 32'(s_r.p2);
        end else if (wb_adr_in == acc_pkg::ADR_PARAM3) begin
          s_nxt.dat = 32'(s_r.p3);
        end else if (wb_adr_in == acc_pkg::ADR_STORE_CFG) begin
          s_nxt.dat = 32'(s_r.created);
        end else if (wb_adr_in == acc_pkg::ADR_STATUS) begin
          s_nxt.dat[acc_pkg::ST_ERR]   = s_r.err;
          s_nxt.dat[acc_pkg::ST_REPLY] = (s_r.rst != acc_pkg::R_IDLE);
          for (int i = 0; i < acc_pkg::NSLOT; i++) begin
            s_nxt.dat[acc_pkg::ST_CAL] = s_nxt.dat[acc_pkg::ST_CAL] | s_r.slot[i].cfg.cal_run;
          end
        end else if (wb_adr_in == acc_pkg::ADR_REPLY) begin
          // Reading pops one character
          if (s_r.rst != acc_pkg::R_IDLE) begin
            s_nxt.dat = {23'h000000, 1'b1, cur_char};
            if (s_r.rst == acc_pkg::R_TERM || (field_end && !nxt_slot[4])) begin
              s_nxt.rst = acc_pkg::R_IDLE;
            end else if (field_end) begin
              s_nxt.rslot = nxt_slot[3:0];
              s_nxt.ridx  = 3'h0;
            end else begin
              s_nxt.ridx = s_r.ridx + 3'h1;
            end
          end
        end
      end
    end

    // Parameter checking for each command
    if (cmd_go) begin
      if (op == acc_pkg::OP_ACL) begin
        bad = !p1_on || (v1 > 16'h0001);
      end else if (op == acc_pkg::OP_AIS) begin
        bad = !(v1[15:6] == 10'h000 && (v1[5:0] == acc_pkg::SRC_ZERO ||
                v1[5:0] == acc_pkg::SRC_CAL || v1[5:0] == acc_pkg::SRC_MEAS));
      end else if (op == acc_pkg::OP_CPV) begin
        bad = p1_on && (v1 == 16'h0000 || v1 > 16'h0003);
      end else if (op == acc_pkg::OP_HPV || op == acc_pkg::OP_HPV_Q) begin
        bad = (v1 == 16'h0000) || (v1 > 16'h0003) || (op == acc_pkg::OP_HPV && v2 > 16'h0001);
      end else if (op == acc_pkg::OP_SAD) begin
        bad = !(v1 == 16'(acc_pkg::EXC_NONE) || v1 == 16'(acc_pkg::EXC_2V5));
      end else if (op > acc_pkg::OP_SAD || op == 4'h0) begin
        bad = 1'b1;
      end
      s_nxt.err = bad;
      // Queries restart the reply walker
      if (!bad && (op == acc_pkg::OP_CAL_Q || op == acc_pkg::OP_ACL_Q ||
                   op == acc_pkg::OP_AIS_Q || op == acc_pkg::OP_HPV_Q ||
                   op == acc_pkg::OP_HPV_LIST)) begin
        s_nxt.rop    = op;
        s_nxt.rstore = v1[1:0];
        s_nxt.rslot  = first[3:0];
        s_nxt.ridx   = 3'h0;
        s_nxt.rst    = first[4] ? acc_pkg::R_FIELD : acc_pkg::R_TERM;
      end
    end

    // Per-slot behaviour
    for (int i = 0; i < acc_pkg::NSLOT; i++) begin
      virt  = (i / acc_pkg::NSUB) == acc_pkg::VIRT_CH;
      sel_i = is_sel(s_r, i) & cmd_go & ~bad;
      m     = $signed(meas_in[i]);

      // Calibration timer
      if (s_r.slot[i].cfg.cal_run) begin
        if (s_r.slot[i].cal_cnt == 30'(CAL_CYC - 1)) begin
          s_nxt.slot[i].cfg.cal_run = 1'b0;
          s_nxt.slot[i].cal_cnt     = 30'h0;
        end else begin
          s_nxt.slot[i].cal_cnt = s_r.slot[i].cal_cnt + 30'h1;
        end
      end

      // Overflow dwell and automatic start
      trig = 1'b0;
      if (overflow_in[i]) begin
        if (s_r.slot[i].ovf_cnt == 30'(OVF_CYC - 1)) begin
          s_nxt.slot[i].ovf_cnt = 30'h0;
          trig = 1'b1;
        end else begin
          s_nxt.slot[i].ovf_cnt = s_r.slot[i].ovf_cnt + 30'h1;
        end
      end else begin
        s_nxt.slot[i].ovf_cnt = 30'h0;
      end
      trig = (trig | sensor_plug_in[i]) & s_r.slot[i].cfg.auto_adjust_enable_cmd & ~virt &
             is_bridge(s_r.slot[i].cfg.ttype);
      if (trig || (sel_i && op == acc_pkg::OP_CAL && !virt)) begin
        s_nxt.slot[i].cfg.cal_run = 1'b1;
        s_nxt.slot[i].cal_cnt     = 30'h0;
      end
      if (sel_i && op == acc_pkg::OP_CAL && !virt) begin
        s_nxt.slot[i].cfg.cal_unlock = 1'b1;
      end

      // Configuration commands
      if (sel_i && op == acc_pkg::OP_ACL) begin
        s_nxt.slot[i].cfg.auto_adjust_enable_cmd = v1[0];
      end
      if (sel_i && op == acc_pkg::OP_AIS && (!virt || v1[5:0] == acc_pkg::SRC_MEAS)) begin
        s_nxt.slot[i].cfg.src = v1[5:0];
      end
      if (sel_i && op == acc_pkg::OP_SAD && !virt) begin
        s_nxt.slot[i].cfg.exc   = v1[4:0];
        s_nxt.slot[i].cfg.ttype = v2[9:0];
        if (s_r.p3[acc_pkg::PARAM_PRESENT]) begin
          s_nxt.slot[i].cfg.sens = s_r.p3[9:0];
        end
      end
      if (sel_i && op == acc_pkg::OP_HPV && !virt) begin
        s_nxt.slot[i].pk.frz[store - 2'h1] = v2[0];
      end

      // Peak tracking, held while frozen
      if (!virt) begin
        if (s_r.created[0] && !s_r.slot[i].pk.frz[0] &&
            m > $signed(s_r.slot[i].pk.mx)) begin
          s_nxt.slot[i].pk.mx = m;
        end
        if (s_r.created[1] && !s_r.slot[i].pk.frz[1] &&
            m < $signed(s_r.slot[i].pk.mn)) begin
          s_nxt.slot[i].pk.mn = m;
        end
        if (s_r.created[2] && !s_r.slot[i].pk.frz[2]) begin
          if (m > $signed(s_r.slot[i].ppmx)) begin
            s_nxt.slot[i].ppmx = m;
          end
          if (m < $signed(s_r.slot[i].ppmn)) begin
            s_nxt.slot[i].ppmn = m;
          end
          s_nxt.slot[i].pk.pp = s_nxt.slot[i].ppmx - s_nxt.slot[i].ppmn;
        end
      end

      // Clear reloads even a frozen store
      if (sel_i && op == acc_pkg::OP_CPV && !virt && s_r.created[store - 2'h1]) begin
        if (store == 2'h1) begin
          s_nxt.slot[i].pk.mx = m;
        end else if (store == 2'h2) begin
          s_nxt.slot[i].pk.mn = m;
        end else begin
          s_nxt.slot[i].ppmx  = m;
          s_nxt.slot[i].ppmn  = m;
          s_nxt.slot[i].pk.pp = 16'h0000;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_r     <= '0;
      s_r.rst <= acc_pkg::R_IDLE;
      for (int i = 0; i < acc_pkg::NSLOT; i++) begin
        s_r.slot[i].cfg.auto_adjust_enable_cmd  <= 1'b1;
        s_r.slot[i].cfg.src  <= acc_pkg::SRC_MEAS;
        s_r.slot[i].cfg.sens <= acc_pkg::SENS_DEF;
        s_r.slot[i].pk.frz   <= 3'h0;
        if ((i / acc_pkg::NSUB) == acc_pkg::VIRT_CH) begin
          s_r.slot[i].cfg.exc   <= acc_pkg::EXC_NONE;
          s_r.slot[i].cfg.ttype <= acc_pkg::TT_VIRT;
        end else begin
          s_r.slot[i].cfg.exc   <= acc_pkg::EXC_2V5;
          s_r.slot[i].cfg.ttype <= acc_pkg::TT_DEF;
        end
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign wb_ack_out        = s_r.ack;
  assign wb_dat_out        = s_r.dat;
  assign store_created_out = s_r.created;

  for (genvar g = 0; g < acc_pkg::NSLOT; g++) begin : g_out
    assign cfg_out[g]  = s_r.slot[g].cfg;
    assign peak_out[g] = s_r.slot[g].pk;
  end

endmodule : acc_ctrl

// ---- rtl/acc_pkg.sv ----
// Package for the amplifier channel command controller.
// Assumes a 200 MHz clock and a fixed set of five channels (index 4 is the
// virtual channel) with two subchannels each.
package acc_pkg;

  // ----------------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------------
  localparam int NCH         = 5;
  localparam int NSUB        = 2;
  localparam int NSLOT       = NCH * NSUB;
  localparam int VIRT_CH     = 4;
  localparam int CLK_KHZ     = 200000;
  localparam int CAL_TIME_MS = 3000;
  localparam int OVF_TIME_MS = 3000;
  localparam int CAL_CYCLES  = CAL_TIME_MS * CLK_KHZ;
  localparam int OVF_CYCLES  = OVF_TIME_MS * CLK_KHZ;

  // ----------------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADR_CHSEL     = 8'h00;
  localparam logic [7:0] ADR_SUBSEL    = 8'h04;
  localparam logic [7:0] ADR_PARAM1    = 8'h08;
  localparam logic [7:0] ADR_PARAM2    = 8'h0C;
  localparam logic [7:0] ADR_PARAM3    = 8'h10;
  localparam logic [7:0] ADR_CMD       = 8'h14;
  localparam logic [7:0] ADR_STATUS    = 8'h18;
  localparam logic [7:0] ADR_REPLY     = 8'h1C;
  localparam logic [7:0] ADR_STORE_CFG = 8'h20;
  localparam int         PARAM_PRESENT = 16;
  localparam int         REPLY_VALID   = 8;
  localparam int         ST_ERR        = 0;
  localparam int         ST_REPLY      = 1;
  localparam int         ST_CAL        = 2;

  // ----------------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------------
  localparam logic [3:0] OP_CAL      = 4'h1;
  localparam logic [3:0] OP_CAL_Q    = 4'h2;
  localparam logic [3:0] OP_ACL      = 4'h3;
  localparam logic [3:0] OP_ACL_Q    = 4'h4;
  localparam logic [3:0] OP_AIS      = 4'h5;
  localparam logic [3:0] OP_AIS_Q    = 4'h6;
  localparam logic [3:0] OP_CPV      = 4'h7;
  localparam logic [3:0] OP_HPV      = 4'h8;
  localparam logic [3:0] OP_HPV_Q    = 4'h9;
  localparam logic [3:0] OP_HPV_LIST = 4'hA;
  localparam logic [3:0] OP_SAD      = 4'hB;

  // ----------------------------------------------------------------------
  // Parameter codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [5:0] SRC_ZERO  = 6'h28;
  localparam logic [5:0] SRC_CAL   = 6'h29;
  localparam logic [5:0] SRC_MEAS  = 6'h2A;
  localparam logic [4:0] EXC_NONE  = 5'h0A;
  localparam logic [4:0] EXC_2V5   = 5'h0D;
  localparam logic [9:0] TT_BR_LO  = 10'h15E;
  localparam logic [9:0] TT_BR_HI  = 10'h181;
  localparam logic [9:0] TT_DEF    = 10'h15E;
  localparam logic [9:0] TT_VIRT   = 10'h23F;
  localparam logic [9:0] SENS_DEF  = 10'h30A;
  localparam logic [7:0] CH_ZERO   = 8'h30;
  localparam logic [7:0] CH_COMMA  = 8'h2C;
  localparam logic [7:0] CH_COLON  = 8'h3A;
  localparam logic [7:0] CH_TERM   = 8'h0A;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    R_IDLE  = 3'b001,
    R_FIELD = 3'b010,
    R_TERM  = 3'b100
  } acc_rstate_e;

  typedef struct packed {
    logic       auto_adjust_enable_cmd;
    logic       cal_run;
    logic       cal_unlock;
    logic [5:0] src;
    logic [4:0] exc;
    logic [9:0] ttype;
    logic [9:0] sens;
  } acc_cfg_s;

  typedef struct packed {
    logic [15:0] mx;
    logic [15:0] mn;
    logic [15:0] pp;
    logic [2:0]  frz;
  } acc_peak_s;

endpackage : acc_pkg

// ---- tb/acc_chk.sv ----
// Port checker for acc_ctrl.
// Assumes one clock domain; bound from tb.
`timescale 1ns/10ps
module acc_chk (
  input wire logic                               clk_in,
  input wire logic                               rstn_in,
  input wire logic                               wb_cyc_in,
  input wire logic                               wb_stb_in,
  input wire logic                               wb_ack_out,
  input wire acc_pkg::acc_cfg_s  [acc_pkg::NSLOT-1:0] cfg_out,
  input wire acc_pkg::acc_peak_s [acc_pkg::NSLOT-1:0] peak_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_req; wb_cyc_in && wb_stb_in && !wb_ack_out; endsequence
  sequence s_run8; cfg_out[0].cal_run [*8]; endsequence
  property p_ack; s_req |=> wb_ack_out ##1 !wb_ack_out; endproperty
  property p_noreq; !(wb_cyc_in && wb_stb_in) |=> !wb_ack_out; endproperty
  property p_rst; $rose(rstn_in) |-> cfg_out[0].auto_adjust_enable_cmd && (peak_out[0].frz == 3'h0); endproperty
  property p_src; cfg_out[0].src inside {6'h28, 6'h29, 6'h2A}; endproperty
  property p_exc; cfg_out[0].exc inside {5'h0A, 5'h0D}; endproperty
  property p_virt; (peak_out[8] == '0) && !cfg_out[8].cal_run; endproperty
  property p_frz; peak_out[0].frz[0] && !wb_stb_in |=> $stable(peak_out[0].mx); endproperty
  property p_cal; $rose(cfg_out[0].cal_run) |-> $stable(cfg_out[0].auto_adjust_enable_cmd) ##0 s_run8; endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after request");
  a_noreq: assert property (p_noreq) else $error("ack without request");
  a_rst: assert property (p_rst) else $error("bad reset state");
  a_src: assert property (p_src) else $error("bad input source");
  a_exc: assert property (p_exc) else $error("bad excitation");
  a_virt: assert property (p_virt) else $error("virtual slot active");
  a_frz: assert property (p_frz) else $error("frozen max moved");
  a_cal: assert property (p_cal) else $error("calibration short or auto changed");
endmodule : acc_chk

// ---- tb/acc_sens.sv ----
// Sensor side model: a ramp on every slot, overflow on request.
// Assumes tb raises ovf_req_in; no plug events.
`timescale 1ns/10ps
module acc_sens (
  input  wire logic                          clk_in,
  input  wire logic                          rstn_in,
  input  wire logic                          ovf_req_in,
  output logic [acc_pkg::NSLOT-1:0][15:0]    meas_out,
  output logic [acc_pkg::NSLOT-1:0]          ovf_out,
  output logic [acc_pkg::NSLOT-1:0]          plug_out
);
  logic [15:0] ramp_r;
  // Rising values make a held max visible
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in)
      ramp_r <= 16'h0000;
    else
      ramp_r <= ramp_r + 16'h0001;
  end
  always_comb begin
    for (int i = 0; i < acc_pkg::NSLOT; i++) meas_out[i] = ramp_r + 16'(i);
  end
  assign ovf_out  = {acc_pkg::NSLOT{ovf_req_in}};
  assign plug_out = '0;
endmodule : acc_sens

// ---- tb/tb.sv ----
// Bench for acc_ctrl: Wishbone tasks, row loop, hand tests.
// Assumes short calibration and overflow counts.
`timescale 1ns/10ps
module tb;
  localparam int CYC = 20;
  logic clk_in = 1'b0, rstn_in = 1'b0, cyc = 1'b0, we = 1'b0, ack, ovf = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, dout;
  logic [acc_pkg::NSLOT-1:0][15:0] meas;
  logic [acc_pkg::NSLOT-1:0] ovfv, plug;
  acc_pkg::acc_cfg_s [acc_pkg::NSLOT-1:0] cfg;
  acc_pkg::acc_peak_s [acc_pkg::NSLOT-1:0] peak;
  logic [15:0] held;
  logic [2:0] crt;
  logic [63:0] hx = 64'h312C_313A_312C_310A;
  int n_errors = 0, n_tests = 0;
  logic [26:0] rows [10] = '{{4'h5, 16'h0028, 1'b0, 6'h28}, {4'h5, 16'h002B, 1'b1, 6'h28},
    {4'h5, 16'h0029, 1'b0, 6'h29}, {4'h5, 16'h002E, 1'b1, 6'h29}, {4'h5, 16'h002A, 1'b0, 6'h2A},
    {4'hB, 16'h000B, 1'b1, 6'h0D}, {4'hB, 16'h000A, 1'b0, 6'h0A}, {4'hB, 16'h000E, 1'b1, 6'h0A},
    {4'hB, 16'h0012, 1'b1, 6'h0A}, {4'hB, 16'h000D, 1'b0, 6'h0D}};
  logic [8:0] ex [4] = '{9'h130, 9'h12C, 9'h130, 9'h10A};
  acc_ctrl #(.CAL_CYC(CYC), .OVF_CYC(CYC)) dut_u (.clk_in, .rstn_in, .wb_cyc_in(cyc),
    .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat),
    .wb_dat_out(dout), .wb_ack_out(ack), .meas_in(meas), .sensor_plug_in(plug),
    .overflow_in(ovfv), .cfg_out(cfg), .peak_out(peak), .store_created_out(crt));
  acc_sens sens_u (.clk_in, .rstn_in, .ovf_req_in(ovf), .meas_out(meas), .ovf_out(ovfv),
    .plug_out(plug));
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_in); while (ack !== 1'b1 && ++t < 50);
    if (t >= 50) n_errors++;
    rdat = dout;
    cyc <= 1'b0;
    @(posedge clk_in);
  endtask : bus
  task automatic cmd(input logic [7:0] a, input logic [15:0] v, input logic [3:0] op);
    bus(1'b1, a, {15'h0000, 1'b1, v});
    bus(1'b1, acc_pkg::ADR_CMD, {28'h0000000, op});
  endtask : cmd
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  initial begin
    #20000;
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    chk(cfg[0].auto_adjust_enable_cmd, 1);
    chk(peak[0].frz, 0);
    bus(1'b1, acc_pkg::ADR_CHSEL, 32'h1);
    bus(1'b1, acc_pkg::ADR_SUBSEL, 32'h1);
    bus(1'b1, acc_pkg::ADR_PARAM2, 32'h1015E);
    foreach (rows[i]) begin
      cmd(acc_pkg::ADR_PARAM1, rows[i][22:7], rows[i][26:23]);
      bus(1'b0, acc_pkg::ADR_STATUS, 32'h0);
      chk(rdat[0], rows[i][6]);
      chk(rows[i][26:23] == 4'h5 ? cfg[0].src : cfg[0].exc, rows[i][5:0]);
    end
    bus(1'b1, acc_pkg::ADR_SUBSEL, 32'h3);
    cmd(acc_pkg::ADR_PARAM1, 16'h0000, acc_pkg::OP_ACL);
    cmd(acc_pkg::ADR_PARAM1, 16'h0000, acc_pkg::OP_ACL_Q);
    foreach (ex[i]) begin
      bus(1'b0, acc_pkg::ADR_REPLY, 32'h0);
      chk(rdat, ex[i]);
    end
    cmd(acc_pkg::ADR_PARAM1, 16'h0000, acc_pkg::OP_CAL);
    chk({cfg[1].cal_run, cfg[0].auto_adjust_enable_cmd, cfg[2].cal_run, cfg[0].cal_unlock}, 4'h9);
    cmd(acc_pkg::ADR_PARAM1, 16'h0000, acc_pkg::OP_CAL_Q);
    bus(1'b0, acc_pkg::ADR_REPLY, 32'h0);
    chk(rdat, 32'h131);
    repeat (CYC + 5) @(posedge clk_in);
    chk(cfg[0].cal_run, 0);
    cmd(acc_pkg::ADR_PARAM1, 16'h0001, acc_pkg::OP_ACL);
    ovf <= 1'b1;
    repeat (CYC + 5) @(posedge clk_in);
    chk(cfg[0].cal_run, 1);
    ovf <= 1'b0;
    bus(1'b1, acc_pkg::ADR_STORE_CFG, 32'h7);
    bus(1'b1, acc_pkg::ADR_PARAM2, 32'h10001);
    cmd(acc_pkg::ADR_PARAM1, 16'h0001, acc_pkg::OP_HPV);
    cmd(acc_pkg::ADR_PARAM1, 16'h0003, acc_pkg::OP_HPV);
    held = peak[0].mx;
    cmd(acc_pkg::ADR_PARAM1, 16'h0003, acc_pkg::OP_CPV);
    repeat (10) @(posedge clk_in);
    chk(peak[0].frz, 3'h5);
    chk({peak[0].mx, peak[0].pp}, {held, 16'h0000});
    chk(crt, 3'h7);
    cmd(acc_pkg::ADR_PARAM1, 16'h0001, acc_pkg::OP_HPV_Q);
    for (int i = 7; i >= 0; i--) begin
      bus(1'b0, acc_pkg::ADR_REPLY, 32'h0);
      chk(rdat, {24'h000001, hx[i*8 +: 8]});
    end
    rstn_in <= 1'b0;
    @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    chk({cfg[0].auto_adjust_enable_cmd, peak[0].frz}, 4'h8);
    end_of_test();
  end
endmodule : tb
bind acc_ctrl acc_chk chk_u (.clk_in, .rstn_in, .wb_cyc_in, .wb_stb_in, .wb_ack_out,
  .cfg_out, .peak_out);
